// ===== shared/sdbg_pkg.sv
// Constants for the serial debug controller: status/control layout,
// command codes and reset values. Assumes byte-level commands arrive
// already decoded from the single-wire link.
// How it works
// - Compare CPU address with 16-bit break address
// - Forced match halts at next instruction boundary
// - Tagged opcode halts when reaching queue end
// - Break enable resets zero, disables all breaks
// - Select bit: one forced, zero tagged
// - Registers reachable only by serial commands
// - Status/control register is eight bits wide
// - Permit bit write blocked while halted
// - Four status flags are read-only
// - Permit cleared by reset, gates halt entry
// - Halt-active flag reads one while halted
// - Clock select resets zero, always writable
// - Wait/stop flag: in low power or woken
// - Halt command wakes CPU from wait/stop
// - Wait/stop fail flag on conflicting memory command
// - Data-valid fail flag unused, reads zero
// - Status read E4, control write C4
// - Break address read E2, write C2
package sdbg_pkg;
   localparam int SDBG_ADDR_W = 16;
   localparam int SDBG_SCR_W = 8;
   // Status/control bit positions
   localparam int SDBG_BIT_PERMIT = 7;
   localparam int SDBG_BIT_HALT_ACT = 6;
   localparam int SDBG_BIT_BRK_EN = 5;
   localparam int SDBG_BIT_FTS = 4;
   localparam int SDBG_BIT_CLKSEL = 3;
   localparam int SDBG_BIT_WS = 2;
   localparam int SDBG_BIT_WSF = 1;
   localparam int SDBG_BIT_DVF = 0;
   // Command codes
   localparam logic [7:0] SDBG_CMD_RD_STATUS = 8'he4;
   localparam logic [7:0] SDBG_CMD_WR_CONTROL = 8'hc4;
   localparam logic [7:0] SDBG_CMD_RD_BRK = 8'he2;
   localparam logic [7:0] SDBG_CMD_WR_BRK = 8'hc2;
   localparam logic [7:0] SDBG_CMD_BACKGROUND = 8'h90;
   localparam logic [7:0] SDBG_CMD_GO = 8'h08;
   // Reset values
   localparam logic [15:0] SDBG_BRK_RST = 16'h0000;
   localparam logic SDBG_CTRL_RST = 1'b0;
   typedef enum logic {SDBG_RUN, SDBG_HALTED} sdbg_halt_t;
endpackage : sdbg_pkg

// ===== shared/sdbg_brk_if.sv
// Breakpoint bundle between the controller and its match unit.
// Assumes one clock domain; all signals are sampled on clk.
`timescale 1ns/1ps
interface sdbg_brk_if;
   logic [15:0] break_addr;
   logic break_enable;
   logic force_or_tag_select;
   logic forced_hit;
   logic tag_mark;
   modport ctrl
   (
      output break_addr,
      output break_enable,
      output force_or_tag_select,
      input forced_hit,
      input tag_mark
   );
   modport match
   (
      input break_addr,
      input break_enable,
      input force_or_tag_select,
      output forced_hit,
      output tag_mark
   );
endinterface : sdbg_brk_if

// ===== src/sdbg_break_match.sv
// Address comparator for the hardware breakpoint.
// Assumes CPU bus signals are synchronous to clk.
`timescale 1ns/1ps
module sdbg_break_match
   import sdbg_pkg::*;
#(
   parameter int ADDR_W = SDBG_ADDR_W
)
(
   // Bundle to controller
   sdbg_brk_if.match brk,
   // CPU bus
   input wire logic [ADDR_W-1:0] cpu_addr,
   input wire logic cpu_access,
   input wire logic cpu_opfetch
);
   logic hit;

   always_comb
   begin
      hit = brk.break_enable && (cpu_addr == brk.break_addr);
   end

   // Forced: any access; tagged: only opcode fetches
   assign brk.forced_hit = hit && cpu_access && brk.force_or_tag_select;
   assign brk.tag_mark = hit && cpu_opfetch && !brk.force_or_tag_select;
endmodule : sdbg_break_match

// ===== src/sdbg_halt_ctl.sv
// Halt state machine: run versus debug halt mode.
// Assumes the CPU reports instruction boundaries and low-power state.
`timescale 1ns/1ps
module sdbg_halt_ctl
   import sdbg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Requests
   input wire logic halt_permit,
   input wire logic forced_hit,
   input wire logic tag_reached,
   input wire logic bg_cmd,
   input wire logic go_cmd,
   // CPU state
   input wire logic cpu_boundary,
   input wire logic cpu_wait_stop,
   // Results
   output logic halt_active,
   output logic woke_from_ws,
   output logic wake_req
);
   sdbg_halt_t state;
   logic req_pend;
   logic enter;
   logic enter_ws;

   always_comb
   begin
      enter_ws = (state == SDBG_RUN) && halt_permit && cpu_wait_stop && (bg_cmd || req_pend);
      enter = (state == SDBG_RUN) && halt_permit
         && ((req_pend && cpu_boundary) || tag_reached || enter_ws);
   end

   // Pending break or halt request until a boundary
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         req_pend <= 1'b0;
      else if (enter || !halt_permit || state == SDBG_HALTED)
         req_pend <= 1'b0;
      else if (forced_hit || bg_cmd)
         req_pend <= 1'b1;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         state <= SDBG_RUN;
      else
      begin
         unique case (state)
            SDBG_RUN:
               if (enter)
                  state <= SDBG_HALTED;
            SDBG_HALTED:
               if (go_cmd)
                  state <= SDBG_RUN;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         woke_from_ws <= 1'b0;
      else if (enter_ws)
         woke_from_ws <= 1'b1;
      else if (state == SDBG_HALTED && go_cmd)
         woke_from_ws <= 1'b0;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         wake_req <= 1'b0;
      else
         wake_req <= enter_ws;
   end

   assign halt_active = (state == SDBG_HALTED);
endmodule : sdbg_halt_ctl

// ===== src/sdbg_controller.sv
// Top of the serial debug controller: command handling for the
// status/control and break address registers, breakpoint and halt logic.
// Assumes the link layer hands over whole decoded commands, one per
// cycle at most, and collects answers from resp_valid/resp_data.
`timescale 1ns/1ps
module sdbg_controller
   import sdbg_pkg::*;
#(
   parameter int ADDR_W = SDBG_ADDR_W
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Decoded serial commands
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   // Command answers
   output logic resp_valid,
   output logic [15:0] resp_data,
   // CPU bus observation
   input wire logic [ADDR_W-1:0] cpu_addr,
   input wire logic cpu_access,
   input wire logic cpu_opfetch,
   input wire logic cpu_boundary,
   input wire logic tag_reached,
   // CPU low-power and memory command status
   input wire logic cpu_wait_stop,
   input wire logic mem_fail_ws,
   // Control to the CPU and clocking
   output logic tag_mark,
   output logic halt_active_flag,
   output logic wake_req,
   output logic comm_clock_select
);
   sdbg_brk_if brk ();

   // Register contents
   logic [ADDR_W-1:0] debug_break_address;
   logic halt_permit;
   logic break_enable;
   logic force_or_tag_select;
   logic wait_stop_fail_flag;
   logic woke_from_ws;
   logic halted;
   logic [SDBG_SCR_W-1:0] debug_status_control;

   // Command decode
   logic do_rd_status;
   logic do_wr_control;
   logic do_rd_brk;
   logic do_wr_brk;
   logic do_bg;
   logic do_go;
   logic wait_stop_status;

   function automatic logic is_cmd(input logic valid, input logic [7:0] code, input logic [7:0] ref_code);
      is_cmd = valid && (code == ref_code);
   endfunction : is_cmd

   // Only serial commands reach the registers
   always_comb
   begin
      do_rd_status = is_cmd(cmd_valid, cmd_code, SDBG_CMD_RD_STATUS);
      do_wr_control = is_cmd(cmd_valid, cmd_code, SDBG_CMD_WR_CONTROL);
      do_rd_brk = is_cmd(cmd_valid, cmd_code, SDBG_CMD_RD_BRK);
      do_wr_brk = is_cmd(cmd_valid, cmd_code, SDBG_CMD_WR_BRK);
      do_bg = is_cmd(cmd_valid, cmd_code, SDBG_CMD_BACKGROUND) && halt_permit;
      do_go = is_cmd(cmd_valid, cmd_code, SDBG_CMD_GO) && halted;
   end

   // Break address register
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         debug_break_address <= SDBG_BRK_RST;
      else if (do_wr_brk)
         debug_break_address <= cmd_wdata[ADDR_W-1:0];
   end

   // Permit bit: cleared by reset, loaded from bit 7 by a control write, frozen while halted
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         halt_permit <= SDBG_CTRL_RST;
      else if (do_wr_control && !halted)
         halt_permit <= cmd_wdata[SDBG_BIT_PERMIT];
   end

   // Breakpoint controls
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         break_enable <= SDBG_CTRL_RST;
         force_or_tag_select <= SDBG_CTRL_RST;
      end
      else if (do_wr_control)
      begin
         break_enable <= cmd_wdata[SDBG_BIT_BRK_EN];
         force_or_tag_select <= cmd_wdata[SDBG_BIT_FTS];
      end
   end

   // Communication clock source select
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         comm_clock_select <= SDBG_CTRL_RST;
      else if (do_wr_control)
         comm_clock_select <= cmd_wdata[SDBG_BIT_CLKSEL];
   end

   // Wait/stop failure: set wins over the clear on status read
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         wait_stop_fail_flag <= 1'b0;
      else if (mem_fail_ws)
         wait_stop_fail_flag <= 1'b1;
      else if (do_rd_status)
         wait_stop_fail_flag <= 1'b0;
   end

   assign wait_stop_status = cpu_wait_stop || woke_from_ws;

   // Status view; flags come only from hardware
   always_comb
   begin
      debug_status_control = '0;
      debug_status_control[SDBG_BIT_PERMIT] = halt_permit;
      debug_status_control[SDBG_BIT_HALT_ACT] = halted;
      debug_status_control[SDBG_BIT_BRK_EN] = break_enable;
      debug_status_control[SDBG_BIT_FTS] = force_or_tag_select;
      debug_status_control[SDBG_BIT_CLKSEL] = comm_clock_select;
      debug_status_control[SDBG_BIT_WS] = wait_stop_status;
      debug_status_control[SDBG_BIT_WSF] = wait_stop_fail_flag;
      debug_status_control[SDBG_BIT_DVF] = 1'b0;
   end

   // Answers: one cycle after the command
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         resp_valid <= 1'b0;
      else
         resp_valid <= do_rd_status || do_rd_brk;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         resp_data <= '0;
      else if (do_rd_status)
         resp_data <= {8'h00, debug_status_control};
      else if (do_rd_brk)
         resp_data <= 16'(debug_break_address);
   end

   // Breakpoint unit
   assign brk.break_addr = debug_break_address;
   assign brk.break_enable = break_enable;
   assign brk.force_or_tag_select = force_or_tag_select;
   assign tag_mark = brk.tag_mark;

   sdbg_break_match #(
      .ADDR_W(ADDR_W)
   ) u_match (
      .brk(brk.match),
      .cpu_addr(cpu_addr),
      .cpu_access(cpu_access),
      .cpu_opfetch(cpu_opfetch)
   );

   // Halt control
   sdbg_halt_ctl u_halt (
      .clk(clk),
      .sys_rst(sys_rst),
      .halt_permit(halt_permit),
      .forced_hit(brk.forced_hit),
      .tag_reached(tag_reached && break_enable),
      .bg_cmd(do_bg),
      .go_cmd(do_go),
      .cpu_boundary(cpu_boundary),
      .cpu_wait_stop(cpu_wait_stop),
      .halt_active(halted),
      .woke_from_ws(woke_from_ws),
      .wake_req(wake_req)
   );

   assign halt_active_flag = halted;
endmodule : sdbg_controller

// ===== dv/sdbg_props.sv
// Checker on the top ports of the serial debug controller.
// Assumes one clock domain and an active high reset.
`timescale 1ns/1ps
module sdbg_props
   import sdbg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Command port
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic resp_valid,
   input wire logic [15:0] resp_data,
   // CPU side
   input wire logic cpu_opfetch,
   input wire logic cpu_wait_stop,
   input wire logic tag_mark,
   input wire logic halt_active_flag,
   input wire logic wake_req,
   input wire logic comm_clock_select
);
   logic rd_st, rd_bk, wr_bk, wr_ct, go;
   assign rd_st = cmd_valid && cmd_code == SDBG_CMD_RD_STATUS;
   assign rd_bk = cmd_valid && cmd_code == SDBG_CMD_RD_BRK;
   assign wr_bk = cmd_valid && cmd_code == SDBG_CMD_WR_BRK;
   assign wr_ct = cmd_valid && cmd_code == SDBG_CMD_WR_CONTROL;
   assign go = cmd_valid && cmd_code == SDBG_CMD_GO;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_read_answer: assert property (rd_st || rd_bk |=> resp_valid) else $error("read unanswered");
   a_write_silent: assert property (wr_bk || wr_ct |=> !resp_valid) else $error("write answered");
   a_status_fixed: assert property (rd_st |=> resp_data[15:8] == 8'h00 && !resp_data[0]) else $error("status");
   a_halt_bit: assert property (rd_st |=> resp_data[6] == $past(halt_active_flag)) else $error("halt bit");
   a_brk_readback: assert property (wr_bk ##1 rd_bk |=> resp_data == $past(cmd_wdata, 2)) else $error("brk");
   a_clock_sel: assert property (wr_ct |=> comm_clock_select == $past(cmd_wdata[3])) else $error("clksel");
   a_halt_holds: assert property (halt_active_flag && !go |=> halt_active_flag) else $error("halt lost");
   a_go_leaves: assert property (halt_active_flag && go |=> !halt_active_flag) else $error("go");
   a_wake_pulse: assert property (wake_req |=> !wake_req) else $error("wake too long");
   a_ws_status: assert property (rd_st && cpu_wait_stop && $past(cpu_wait_stop) |=> resp_data[2]) else $error("ws");
   a_tag_fetch: assert property (tag_mark |-> cpu_opfetch) else $error("tag off fetch");
   c_halt: cover property ($rose(halt_active_flag));
   c_tag: cover property (tag_mark);
   c_wake: cover property (wake_req);
endmodule : sdbg_props

// ===== dv/sdbg_host_model.sv
// Debug host model issuing decoded serial commands.
// Assumes the caller stands at a falling clock edge.
`timescale 1ns/1ps
module sdbg_host_model
(
   // Clock
   input wire logic clk,
   // Command side
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata,
   // Answer side
   input wire logic resp_valid,
   input wire logic [15:0] resp_data
);
   logic got;
   logic [15:0] ans;
   initial
   begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   // Keep high for a back-to-back command, else release
   task send(input logic [7:0] c, input logic [15:0] d, input logic k);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_wdata = d;
      @(negedge clk);
      got = resp_valid;
      ans = resp_data;
      if (!k)
      begin
         cmd_valid = 1'b0;
         cmd_code = ~c;
         cmd_wdata = ~d;
         @(negedge clk);
      end
   endtask : send
endmodule : sdbg_host_model

// ===== dv/debug_breakpoint_and_status_test.sv
// Self-checking bench for the debug controller top.
// Assumes the host model as command source.
`timescale 1ns/1ps
module debug_breakpoint_and_status_test;
   import sdbg_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1;
   logic [15:0] cpu_addr = 16'h0000;
   logic cpu_access = 1'b0, cpu_opfetch = 1'b0, cpu_boundary = 1'b0;
   logic tag_reached = 1'b0, cpu_wait_stop = 1'b0, mem_fail_ws = 1'b0;
   logic cmd_valid, resp_valid, tag_mark, halt_active_flag, wake_req, comm_clock_select;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, resp_data;
   int n_errors = 0, checked = 0, cyc = 0, wakes = 0;
   always #12.5 clk = ~clk;
   sdbg_controller uut (.clk, .sys_rst, .cmd_valid, .cmd_code, .cmd_wdata, .resp_valid, .resp_data,
      .cpu_addr, .cpu_access, .cpu_opfetch, .cpu_boundary, .tag_reached, .cpu_wait_stop, .mem_fail_ws,
      .tag_mark, .halt_active_flag, .wake_req, .comm_clock_select);
   sdbg_host_model host (.clk, .cmd_valid, .cmd_code, .cmd_wdata, .resp_valid, .resp_data);
   task give_verdict;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   always @(posedge clk)
   begin
      cyc++;
      if (wake_req === 1'b1)
         wakes++;
      if (cyc == 3000)
      begin
         n_errors++;
         give_verdict;
      end
   end
   task chk(input logic [16:0] g, input logic [16:0] e);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task rd_chk(input logic [7:0] c, input logic [15:0] e);
      host.send(c, 16'h0000, 1'b0);
      chk({host.got, host.ans}, {1'b1, e});
   endtask : rd_chk
   // Access, opcode fetch, boundary for one cycle
   task bus(input logic [15:0] a, input logic [2:0] abo);
      cpu_addr = a;
      {cpu_access, cpu_opfetch, cpu_boundary} = abo;
      @(negedge clk);
   endtask : bus
   task s_reset_disabled;
      rd_chk(SDBG_CMD_RD_STATUS, 16'h0000);
      rd_chk(SDBG_CMD_RD_BRK, 16'h0000);
      host.send(SDBG_CMD_WR_BRK, 16'h1234, 1'b1);
      rd_chk(SDBG_CMD_RD_BRK, 16'h1234);
      bus(16'h1234, 3'b110);
      chk(17'(tag_mark), 17'h00000);
      bus(16'h1234, 3'b001);
      bus(16'h0000, 3'b000);
      chk(17'(halt_active_flag), 17'h00000);
   endtask : s_reset_disabled
   task s_forced;
      host.send(SDBG_CMD_WR_CONTROL, 16'h00ff, 1'b0);
      chk(17'(comm_clock_select), 17'h00001);
      rd_chk(SDBG_CMD_RD_STATUS, 16'h00b8);
      bus(16'h1234, 3'b100);
      bus(16'h0000, 3'b001);
      bus(16'h0000, 3'b000);
      chk(17'(halt_active_flag), 17'h00001);
      rd_chk(SDBG_CMD_RD_STATUS, 16'h00f8);
      host.send(SDBG_CMD_WR_CONTROL, 16'h0030, 1'b0);
      rd_chk(SDBG_CMD_RD_STATUS, 16'h00f0);
      host.send(SDBG_CMD_GO, 16'h0000, 1'b0);
      chk(17'(halt_active_flag), 17'h00000);
   endtask : s_forced
   task s_tagged;
      host.send(SDBG_CMD_WR_CONTROL, 16'h00a0, 1'b0);
      bus(16'h1234, 3'b110);
      chk(17'(tag_mark), 17'h00001);
      bus(16'h1234, 3'b100);
      chk(17'(halt_active_flag), 17'h00000);
      tag_reached = 1'b1;
      bus(16'h0000, 3'b000);
      tag_reached = 1'b0;
      bus(16'h0000, 3'b000);
      chk(17'(halt_active_flag), 17'h00001);
      host.send(SDBG_CMD_GO, 16'h0000, 1'b0);
   endtask : s_tagged
   task s_no_permit;
      host.send(SDBG_CMD_WR_CONTROL, 16'h0000, 1'b0);
      host.send(SDBG_CMD_BACKGROUND, 16'h0000, 1'b0);
      bus(16'h0000, 3'b001);
      bus(16'h0000, 3'b000);
      chk(17'(halt_active_flag), 17'h00000);
   endtask : s_no_permit
   task s_wait_stop;
      host.send(SDBG_CMD_WR_CONTROL, 16'h0080, 1'b0);
      cpu_wait_stop = 1'b1;
      bus(16'h0000, 3'b000);
      rd_chk(SDBG_CMD_RD_STATUS, 16'h0084);
      mem_fail_ws = 1'b1;
      bus(16'h0000, 3'b000);
      mem_fail_ws = 1'b0;
      rd_chk(SDBG_CMD_RD_STATUS, 16'h0086);
      rd_chk(SDBG_CMD_RD_STATUS, 16'h0084);
      host.send(SDBG_CMD_BACKGROUND, 16'h0000, 1'b0);
      cpu_wait_stop = 1'b0;
      bus(16'h0000, 3'b000);
      rd_chk(SDBG_CMD_RD_STATUS, 16'h00c4);
      host.send(SDBG_CMD_GO, 16'h0000, 1'b0);
      rd_chk(SDBG_CMD_RD_STATUS, 16'h0080);
      chk(17'(wakes), 17'h00001);
   endtask : s_wait_stop
   // Reset in mid-run must clear permit, controls and break address
   task s_mid_reset;
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      rd_chk(SDBG_CMD_RD_STATUS, 16'h0000);
      rd_chk(SDBG_CMD_RD_BRK, 16'h0000);
      host.send(SDBG_CMD_WR_BRK, 16'habcd, 1'b0);
      chk(17'(host.got), 17'h00000);
      rd_chk(SDBG_CMD_RD_BRK, 16'habcd);
   endtask : s_mid_reset
   initial
   begin
      repeat (12) @(negedge clk);
      sys_rst = 1'b0;
      s_reset_disabled;
      s_forced;
      s_tagged;
      s_no_permit;
      s_wait_stop;
      s_mid_reset;
      give_verdict;
   end
endmodule : debug_breakpoint_and_status_test
bind sdbg_controller sdbg_props chk_i (.clk, .sys_rst, .cmd_valid, .cmd_code, .cmd_wdata, .resp_valid,
   .resp_data, .cpu_opfetch, .cpu_wait_stop, .tag_mark, .halt_active_flag, .wake_req, .comm_clock_select);
